// ===== rtl/usb_ctrl_cfg.svh
// register map, field positions and reset values of the usb config block
`ifndef USB_CTRL_CFG_SVH
`define USB_CTRL_CFG_SVH
`define OFS_DESC_MID     8'h00
`define OFS_DESC_TOP     8'h04
`define OFS_MOD_CFG      8'h08
`define OFS_PWR_CTRL     8'h0c
`define OFS_EP_BASE      8'h40
`define OFS_EP_LAST      8'h7c
`define CFG_EYE_BIT      7
`define CFG_OEMON_BIT    6
`define CFG_SIDL_BIT     4
`define CFG_ASUSP_BIT    0
`define PWR_SUSP_BIT     1
`define EP_STALL_BIT     1
`define CFG_WMASK        8'hd1
`define PWR_WMASK        8'h02
`define EP_WMASK         8'hdf
`define DESC_ALIGN_BITS  9
`define RST_BYTE         8'h00
`define PID_SETUP        4'hd
`define PID_IN           4'h9
`define PID_OUT          4'h1
`endif

// ===== rtl/usb_ctrl_pkg.sv
// types shared by the usb config and endpoint control block
package usb_ctrl_pkg;
	typedef struct packed {
		logic low_speed_direct;
		logic nak_retry_disable;
		logic rsvd;
		logic control_xfer_disable;
		logic endpoint_rx_enable;
		logic endpoint_tx_enable;
		logic endpoint_stalled;
		logic endpoint_handshake_enable;
	} ep_ctrl_t;

	typedef struct packed {
		logic       valid;
		logic [3:0] pid;
		logic [3:0] ep;
	} token_t;

	typedef enum logic [1:0] {
		VERDICT_NONE   = 2'b00,
		VERDICT_ACCEPT = 2'b01,
		VERDICT_REJECT = 2'b10
	} verdict_t;
endpackage

// ===== rtl/usb_stall_flag.sv
// one endpoint stall flag: hardware sets, software writes
`timescale 1ns/1ns
`include "usb_ctrl_cfg.svh"
module usb_stall_flag (
	// clock and reset
	input  wire logic clk,
	input  wire logic nrst,
	// set and write
	input  wire logic hw_set,
	input  wire logic sw_wr,
	input  wire logic sw_val,
	// state
	output logic      flag
);
	logic flag_ff;

	// hardware set wins over a software clear in the same cycle
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			flag_ff <= 1'b0;
		end else if (hw_set) begin
			flag_ff <= 1'b1;
		end else if (sw_wr) begin
			flag_ff <= sw_val;
		end
	end

	assign flag = flag_ff;

	a_set_wins: assert property (@(posedge clk) disable iff (!nrst) hw_set |=> flag_ff)
		else $error("stall flag not set after hardware stall");
endmodule

// ===== rtl/usb_ep_token_check.sv
// decides whether an endpoint takes a token and whether it handshakes
`timescale 1ns/1ns
`include "usb_ctrl_cfg.svh"
module usb_ep_token_check
	import usb_ctrl_pkg::*;
(
	// endpoint settings and token
	input  usb_ctrl_pkg::ep_ctrl_t ctrl,
	input  wire logic [3:0]        pid,
	// decision
	output usb_ctrl_pkg::verdict_t verdict,
	output logic                   handshake
);
	import usb_ctrl_pkg::*;

	logic both_dir;

	assign both_dir  = ctrl.endpoint_tx_enable & ctrl.endpoint_rx_enable;
	assign handshake = ctrl.endpoint_handshake_enable;

	always_comb begin
		verdict = VERDICT_REJECT;
		unique case (pid)
			`PID_OUT: if (ctrl.endpoint_rx_enable) verdict = VERDICT_ACCEPT;
			`PID_IN: if (ctrl.endpoint_tx_enable) verdict = VERDICT_ACCEPT;
			// control-disable only counts when both directions are on
			`PID_SETUP: if (ctrl.endpoint_rx_enable && !(both_dir && ctrl.control_xfer_disable)) verdict = VERDICT_ACCEPT;
			default: verdict = VERDICT_NONE;
		endcase
	end
endmodule

// ===== rtl/usb_config_endpoint_ctrl.sv
// usb descriptor base, module config and endpoint control registers
//
// Chosen here: the placing of the registers and the Wishbone register port.
`timescale 1ns/1ns
`include "usb_ctrl_cfg.svh"
module usb_config_endpoint_ctrl
	import usb_ctrl_pkg::*;
(
	// clock and reset
	input  wire logic                   CLK,
	input  wire logic                   NRST,
	// wishbone slave
	input  wire logic                   WB_CYC_I,
	input  wire logic                   WB_STB_I,
	input  wire logic                   WB_WE_I,
	input  wire logic [7:0]             WB_ADR_I,
	input  wire logic [3:0]             WB_SEL_I,
	input  wire logic [31:0]            WB_DAT_I,
	output logic [31:0]                 WB_DAT_O,
	output logic                        WB_ACK_O,
	// system power state, role and low descriptor base bits
	input  wire logic                   IDLE_MODE,
	input  wire logic                   SLEEP_MODE,
	input  wire logic                   HOST_MODE,
	input  wire logic [6:0]             DESC_BASE_LOW,
	// transceiver and token engine
	input  wire logic                   LINE_DRIVING,
	input  usb_ctrl_pkg::token_t        TOKEN,
	input  wire logic                   STALL_EVENT,
	input  wire logic [3:0]             STALL_EP,
	// control outputs
	output logic [31:0]                 DESC_BASE,
	output logic                        EYE_TEST,
	output logic                        OE_MONITOR,
	output logic                        MODULE_STOPPED,
	output logic                        MODULE_SUSPENDED,
	output logic                        CLK48_ENABLE,
	output logic                        LS_DIRECT,
	output logic                        PREAMBLE_NEEDED,
	output logic                        NAK_RETRY,
	// token decision
	output logic                        TOKEN_ACCEPT,
	output logic                        TOKEN_REJECT,
	output logic                        TOKEN_HANDSHAKE
);
	import usb_ctrl_pkg::*;

	logic [7:0]  desc_mid_ff;
	logic [7:0]  desc_top_ff;
	logic [7:0]  mod_cfg_ff;
	logic [7:0]  pwr_ctrl_ff;
	ep_ctrl_t    ep_ff [16];
	logic [15:0] stall_flag;
	logic        ack_ff;
	logic [31:0] dat_ff;
	logic        req;
	logic        wr_commit;
	logic [31:0] nxt_dat;
	verdict_t    verdict;
	logic        hshk;
	logic [31:0] desc_base_ff;
	logic        eye_ff;
	logic        oe_mon_ff;
	logic        stopped_ff;
	logic        susp_ff;
	logic        clk48_ff;
	logic        ls_direct_ff;
	logic        preamble_ff;
	logic        nak_retry_ff;
	logic        tok_acc_ff;
	logic        tok_rej_ff;
	logic        tok_hshk_ff;

	// true when the address falls in the endpoint window
	function automatic logic ep_hit(input logic [7:0] adr);
		return (adr >= `OFS_EP_BASE) && (adr <= `OFS_EP_LAST);
	endfunction

	// endpoint index from a word address in the window
	function automatic logic [3:0] ep_index(input logic [7:0] adr);
		logic [7:0] rel;
		rel = adr - `OFS_EP_BASE;
		return rel[5:2];
	endfunction

	// only the low byte lane holds implemented bits
	function automatic logic [7:0] merge(input logic [7:0] old, input logic [7:0] wmask);
		return (old & ~wmask) | (WB_DAT_I[7:0] & wmask);
	endfunction

	assign req       = WB_CYC_I & WB_STB_I;
	// a write lands on the edge at which the master sees ack
	assign wr_commit = req & ack_ff & WB_WE_I & WB_SEL_I[0];

	// bus answer: ack one cycle after the request, then dropped
	always_ff @(posedge CLK or negedge NRST) begin
		if (!NRST) begin
			ack_ff <= 1'b0;
		end else begin
			ack_ff <= req & ~ack_ff;
		end
	end

	// read mux; unmapped addresses read zero
	always_comb begin
		nxt_dat = 32'h0000_0000;
		if (ep_hit({WB_ADR_I[7:2], 2'b00})) begin
			nxt_dat[7:0] = ep_ff[ep_index({WB_ADR_I[7:2], 2'b00})];
		end else begin
			unique case ({WB_ADR_I[7:2], 2'b00})
				`OFS_DESC_MID: nxt_dat[7:0] = desc_mid_ff;
				`OFS_DESC_TOP: nxt_dat[7:0] = desc_top_ff;
				`OFS_MOD_CFG:  nxt_dat[7:0] = mod_cfg_ff;
				`OFS_PWR_CTRL: nxt_dat[7:0] = pwr_ctrl_ff;
				default:       nxt_dat[7:0] = 8'h00;
			endcase
		end
	end

	always_ff @(posedge CLK or negedge NRST) begin
		if (!NRST) begin
			dat_ff <= 32'h0000_0000;
		end else if (req & ~ack_ff) begin
			dat_ff <= nxt_dat;
		end else begin
			dat_ff <= 32'h0000_0000;
		end
	end

	// descriptor base bytes
	always_ff @(posedge CLK or negedge NRST) begin
		if (!NRST) begin
			desc_mid_ff <= `RST_BYTE;
			desc_top_ff <= `RST_BYTE;
		end else if (wr_commit) begin
			if ({WB_ADR_I[7:2], 2'b00} == `OFS_DESC_MID) begin
				desc_mid_ff <= WB_DAT_I[7:0];
			end
			if ({WB_ADR_I[7:2], 2'b00} == `OFS_DESC_TOP) begin
				desc_top_ff <= WB_DAT_I[7:0];
			end
		end
	end

	// module config and power control
	always_ff @(posedge CLK or negedge NRST) begin
		if (!NRST) begin
			mod_cfg_ff  <= `RST_BYTE;
			pwr_ctrl_ff <= `RST_BYTE;
		end else if (wr_commit) begin
			if ({WB_ADR_I[7:2], 2'b00} == `OFS_MOD_CFG) begin
				mod_cfg_ff <= merge(mod_cfg_ff, `CFG_WMASK);
			end
			if ({WB_ADR_I[7:2], 2'b00} == `OFS_PWR_CTRL) begin
				pwr_ctrl_ff <= merge(pwr_ctrl_ff, `PWR_WMASK);
			end
		end
	end

	// endpoint registers; stall bit kept by its own flag
	genvar g;
	generate
		for (g = 0; g < 16; g++) begin : gen_ep
			logic ep_wr;
			logic ep_set;

			assign ep_wr  = wr_commit && ep_hit({WB_ADR_I[7:2], 2'b00}) &&
				(ep_index({WB_ADR_I[7:2], 2'b00}) == 4'(g));
			assign ep_set = STALL_EVENT && (STALL_EP == 4'(g));

			always_ff @(posedge CLK or negedge NRST) begin
				if (!NRST) begin
					ep_ff[g] <= ep_ctrl_t'(`RST_BYTE);
				end else begin
					if (ep_wr) begin
						ep_ff[g] <= ep_ctrl_t'(merge(ep_ff[g], `EP_WMASK));
					end
					ep_ff[g].endpoint_stalled <= stall_flag[g];
				end
			end

			usb_stall_flag u_stall (
				.clk    (CLK),
				.nrst   (NRST),
				.hw_set (ep_set),
				.sw_wr  (ep_wr),
				.sw_val (WB_DAT_I[`EP_STALL_BIT]),
				.flag   (stall_flag[g])
			);
		end
	endgenerate

	// token decision for the addressed endpoint
	usb_ep_token_check u_tok (
		.ctrl      (ep_ff[TOKEN.ep]),
		.pid       (TOKEN.pid),
		.verdict   (verdict),
		.handshake (hshk)
	);

	always_ff @(posedge CLK or negedge NRST) begin
		if (!NRST) begin
			tok_acc_ff  <= 1'b0;
			tok_rej_ff  <= 1'b0;
			tok_hshk_ff <= 1'b0;
		end else begin
			tok_acc_ff  <= TOKEN.valid && (verdict == VERDICT_ACCEPT);
			tok_rej_ff  <= TOKEN.valid && (verdict == VERDICT_REJECT);
			tok_hshk_ff <= TOKEN.valid && (verdict == VERDICT_ACCEPT) && hshk;
		end
	end

	// mode outputs
	always_ff @(posedge CLK or negedge NRST) begin
		if (!NRST) begin
			desc_base_ff <= 32'h0000_0000;
			eye_ff       <= 1'b0;
			oe_mon_ff    <= 1'b0;
			stopped_ff   <= 1'b0;
			susp_ff      <= 1'b0;
			clk48_ff     <= 1'b0;
		end else begin
			desc_base_ff <= {desc_top_ff, desc_mid_ff, DESC_BASE_LOW, {`DESC_ALIGN_BITS{1'b0}}};
			eye_ff       <= mod_cfg_ff[`CFG_EYE_BIT];
			oe_mon_ff    <= mod_cfg_ff[`CFG_OEMON_BIT] & LINE_DRIVING;
			stopped_ff   <= mod_cfg_ff[`CFG_SIDL_BIT] & IDLE_MODE;
			susp_ff      <= pwr_ctrl_ff[`PWR_SUSP_BIT] | (mod_cfg_ff[`CFG_ASUSP_BIT] & SLEEP_MODE);
			clk48_ff     <= ~(pwr_ctrl_ff[`PWR_SUSP_BIT] | (mod_cfg_ff[`CFG_ASUSP_BIT] & SLEEP_MODE));
		end
	end

	// host-only settings of endpoint 0
	always_ff @(posedge CLK or negedge NRST) begin
		if (!NRST) begin
			ls_direct_ff <= 1'b0;
			preamble_ff  <= 1'b0;
			nak_retry_ff <= 1'b0;
		end else begin
			ls_direct_ff <= HOST_MODE & ep_ff[0].low_speed_direct;
			preamble_ff  <= HOST_MODE & ~ep_ff[0].low_speed_direct;
			nak_retry_ff <= HOST_MODE & ~ep_ff[0].nak_retry_disable;
		end
	end

	assign WB_ACK_O         = ack_ff;
	assign WB_DAT_O         = dat_ff;
	assign DESC_BASE        = desc_base_ff;
	assign EYE_TEST         = eye_ff;
	assign OE_MONITOR       = oe_mon_ff;
	assign MODULE_STOPPED   = stopped_ff;
	assign MODULE_SUSPENDED = susp_ff;
	assign CLK48_ENABLE     = clk48_ff;
	assign LS_DIRECT        = ls_direct_ff;
	assign PREAMBLE_NEEDED  = preamble_ff;
	assign NAK_RETRY        = nak_retry_ff;
	assign TOKEN_ACCEPT     = tok_acc_ff;
	assign TOKEN_REJECT     = tok_rej_ff;
	assign TOKEN_HANDSHAKE  = tok_hshk_ff;

	default clocking cb @(posedge CLK); endclocking
	default disable iff (!NRST);

	a_ack_single: assert property (WB_ACK_O |=> !WB_ACK_O)
		else $error("ack held longer than one cycle");
	a_upper_zero: assert property (WB_ACK_O |-> WB_DAT_O[31:8] == 24'h000000)
		else $error("upper read bits not zero");
	a_mid_write: assert property (wr_commit && {WB_ADR_I[7:2], 2'b00} == `OFS_DESC_MID
		|=> ##1 DESC_BASE[23:16] == $past(WB_DAT_I[7:0], 2))
		else $error("base bits 23:16 not from written byte");
	a_top_write: assert property (wr_commit && {WB_ADR_I[7:2], 2'b00} == `OFS_DESC_TOP
		|=> ##1 DESC_BASE[31:24] == $past(WB_DAT_I[7:0], 2))
		else $error("base bits 31:24 not from written byte");
	a_base_align: assert property (DESC_BASE[8:0] == 9'h000)
		else $error("descriptor base not aligned");
	a_cfg_unused: assert property (wr_commit && {WB_ADR_I[7:2], 2'b00} == `OFS_MOD_CFG
		|=> (mod_cfg_ff & ~`CFG_WMASK) == 8'h00)
		else $error("unused config bits took a write");
	a_eye_test: assert property ($rose(mod_cfg_ff[`CFG_EYE_BIT]) |=> EYE_TEST)
		else $error("eye test not enabled");
	a_oe_monitor: assert property (OE_MONITOR |-> $past(mod_cfg_ff[`CFG_OEMON_BIT] && LINE_DRIVING))
		else $error("oe monitor active without cause");
	a_idle_stop: assert property (IDLE_MODE && mod_cfg_ff[`CFG_SIDL_BIT] |=> MODULE_STOPPED)
		else $error("module not stopped in idle");
	a_auto_susp: assert property (SLEEP_MODE && mod_cfg_ff[`CFG_ASUSP_BIT] |=> MODULE_SUSPENDED && !CLK48_ENABLE)
		else $error("no automatic suspend on sleep");
	a_sw_susp: assert property (pwr_ctrl_ff[`PWR_SUSP_BIT] |=> !CLK48_ENABLE)
		else $error("48 MHz clock runs while suspended");
	a_ls_direct: assert property (HOST_MODE && ep_ff[0].low_speed_direct |=> LS_DIRECT && !PREAMBLE_NEEDED)
		else $error("low-speed direct not applied");
	a_nak_retry: assert property (HOST_MODE && ep_ff[0].nak_retry_disable |=> !NAK_RETRY)
		else $error("retry not disabled");
	a_setup_reject: assert property (TOKEN.valid && TOKEN.pid == `PID_SETUP
		&& ep_ff[TOKEN.ep].endpoint_tx_enable && ep_ff[TOKEN.ep].endpoint_rx_enable
		&& ep_ff[TOKEN.ep].control_xfer_disable |=> TOKEN_REJECT)
		else $error("setup not rejected");
	a_rx_gate: assert property (TOKEN.valid && TOKEN.pid == `PID_OUT && !ep_ff[TOKEN.ep].endpoint_rx_enable
		|=> !TOKEN_ACCEPT)
		else $error("data taken with receive disabled");
	a_tx_gate: assert property (TOKEN.valid && TOKEN.pid == `PID_IN && !ep_ff[TOKEN.ep].endpoint_tx_enable
		|=> !TOKEN_ACCEPT)
		else $error("data sent with transmit disabled");
	a_rx_accept: assert property (TOKEN.valid && TOKEN.pid == `PID_OUT && ep_ff[TOKEN.ep].endpoint_rx_enable
		|=> TOKEN_ACCEPT)
		else $error("receive token refused with receive enabled");
	a_tx_accept: assert property (TOKEN.valid && TOKEN.pid == `PID_IN && ep_ff[TOKEN.ep].endpoint_tx_enable
		|=> TOKEN_ACCEPT)
		else $error("transmit token refused with transmit enabled");
	// endpoint index taken from the cycle of the stall event
	a_stall_show: assert property (STALL_EVENT
		|=> ##1 ep_ff[$past(STALL_EP, 2)].endpoint_stalled ##1 ep_ff[$past(STALL_EP, 3)].endpoint_stalled)
		else $error("stall not shown in endpoint register");
	a_hshk_gate: assert property (TOKEN_HANDSHAKE |-> TOKEN_ACCEPT)
		else $error("handshake on rejected token");
	a_hshk_sent: assert property (TOKEN.valid && TOKEN.pid == `PID_IN && ep_ff[TOKEN.ep].endpoint_tx_enable
		&& ep_ff[TOKEN.ep].endpoint_handshake_enable |=> TOKEN_HANDSHAKE)
		else $error("handshake missing on accepted token");
	a_hshk_quiet: assert property (TOKEN.valid && !ep_ff[TOKEN.ep].endpoint_handshake_enable
		|=> !TOKEN_HANDSHAKE)
		else $error("handshake sent while disabled");
	a_preamble: assert property (HOST_MODE && !ep_ff[0].low_speed_direct |=> PREAMBLE_NEEDED && !LS_DIRECT)
		else $error("preamble not asked for without direct link");
	a_nak_retry_on: assert property (HOST_MODE && !ep_ff[0].nak_retry_disable |=> NAK_RETRY)
		else $error("retry not enabled");
	a_host_only: assert property (!HOST_MODE |=> !LS_DIRECT && !PREAMBLE_NEEDED && !NAK_RETRY)
		else $error("host settings active outside host role");
	a_ack_answer: assert property (WB_CYC_I && WB_STB_I && !WB_ACK_O |=> WB_ACK_O)
		else $error("request not answered in one cycle");

	c_read: cover property (WB_ACK_O && !WB_WE_I);
	c_write_ep: cover property (wr_commit && ep_hit({WB_ADR_I[7:2], 2'b00}));
	c_setup_ok: cover property (TOKEN.valid && TOKEN.pid == `PID_SETUP ##1 TOKEN_ACCEPT);
	c_auto_susp: cover property ($rose(MODULE_SUSPENDED));
	c_stall: cover property (STALL_EVENT);
endmodule

// ===== test/usb_bus_partner.sv
// token source standing in for the usb bus side
`timescale 1ns/1ns
module usb_bus_partner
	import usb_ctrl_pkg::*;
(
	// clock
	input  wire logic            clk,
	// token request from the bench
	input  wire logic            req,
	input  wire logic [3:0]      req_pid,
	input  wire logic [3:0]      req_ep,
	// bus side
	output usb_ctrl_pkg::token_t token
);
	logic [7:0] junk_ff = 8'h5a;

	// fields keep changing while no token is valid
	always_ff @(posedge clk) begin
		junk_ff <= ~junk_ff + 8'h01;
	end
	assign token = req ? {1'b1, req_pid, req_ep} : {1'b0, junk_ff};
endmodule

// ===== test/usb_config_endpoint_ctrl_tb.sv
// self-checking bench for the usb config and endpoint control block
`timescale 1ns/1ns
`include "usb_ctrl_cfg.svh"
module usb_config_endpoint_ctrl_tb;
	import usb_ctrl_pkg::*;
	logic        CLK = 0, NRST = 0, cyc = 0, stb = 0, we = 0, ack;
	logic [7:0]  adr = '0;
	logic [3:0]  sel = 4'hf, stl_ep = '0, tpid = '0, tep = '0;
	logic [31:0] dat = '0, rdat, q, desc;
	logic        idle = 0, sleep = 0, host = 0, drv = 0, stl = 0, treq = 0;
	logic [6:0]  low = '0;
	logic        eye, oem, stp, susp, c48, lsd, pre, nakr, acc, rej, hsk;
	token_t      tok;
	int          n_fail = 0, checks_done = 0, mid_m, top_m, cfg_m, pwr_m, v, e, k;
	int          ep_m[16];
	int          pids[4] = '{13, 9, 1, 6};

	usb_bus_partner usb_bus_partner_inst (.clk(CLK), .req(treq), .req_pid(tpid), .req_ep(tep), .token(tok));

	usb_config_endpoint_ctrl usb_config_endpoint_ctrl_inst (
		.CLK(CLK), .NRST(NRST), .WB_CYC_I(cyc), .WB_STB_I(stb), .WB_WE_I(we), .WB_ADR_I(adr),
		.WB_SEL_I(sel), .WB_DAT_I(dat), .WB_DAT_O(rdat), .WB_ACK_O(ack), .IDLE_MODE(idle),
		.SLEEP_MODE(sleep), .HOST_MODE(host), .DESC_BASE_LOW(low), .LINE_DRIVING(drv), .TOKEN(tok),
		.STALL_EVENT(stl), .STALL_EP(stl_ep), .DESC_BASE(desc), .EYE_TEST(eye), .OE_MONITOR(oem),
		.MODULE_STOPPED(stp), .MODULE_SUSPENDED(susp), .CLK48_ENABLE(c48), .LS_DIRECT(lsd),
		.PREAMBLE_NEEDED(pre), .NAK_RETRY(nakr), .TOKEN_ACCEPT(acc), .TOKEN_REJECT(rej),
		.TOKEN_HANDSHAKE(hsk));

	initial begin
		forever #5 CLK = ~CLK;
	end

	task automatic conclude;
		$display("checks %0d mismatches %0d", checks_done, n_fail);
		if (n_fail == 0 && checks_done > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		checks_done++;
		if (got !== exp) begin
			n_fail++;
			$display("FAIL %0t got %h expected %h", $time, got, exp);
		end
	endtask

	// one classic cycle; read data lands in q
	task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
		int n;
		n = 0;
		cyc <= 1;
		stb <= 1;
		we <= w;
		adr <= a;
		dat <= d;
		do begin
			@(posedge CLK);
			n++;
		end while (ack !== 1'b1 && n < 20);
		q = rdat;
		cyc <= 0;
		stb <= 0;
		@(posedge CLK);
		chk(n < 20, 1);
	endtask

	task automatic settle;
		repeat (3) @(posedge CLK);
	endtask

	task automatic send(input int pd, input int ep, input int c);
		int ok;
		@(posedge CLK);
		treq <= 1;
		tpid <= 4'(pd);
		tep <= 4'(ep);
		@(posedge CLK);
		treq <= 0;
		@(posedge CLK);
		ok = (pd == 9) ? (c >> 2 & 1) : (c >> 3 & 1) && !(pd == 13 && (c & 8'h1c) == 8'h1c);
		v = (pd == 1 || pd == 9 || pd == 13);
		chk(acc, v && ok);
		chk(rej, v && !ok);
		chk(hsk, v && ok && (c & 1));
	endtask

	initial begin
		#500000;
		n_fail++;
		conclude;
	end

	initial begin
		void'($urandom(32'ha364a8e2));
		repeat (4) @(posedge CLK);
		NRST <= 1;
		// reset values, unmapped places included
		for (e = 0; e < 34; e++) begin
			wb(0, 8'(4 * e), $urandom);
			chk(q, 0);
		end
		for (e = 0; e < 4; e++) begin
			mid_m = $urandom;
			top_m = $urandom;
			low <= 7'($urandom);
			wb(1, `OFS_DESC_MID, mid_m);
			wb(1, `OFS_DESC_TOP, top_m);
			sel <= 4'he;
			wb(1, `OFS_DESC_MID, ~mid_m);
			sel <= 4'hf;
			wb(0, `OFS_DESC_MID, 0);
			chk(q, mid_m & 255);
			wb(0, `OFS_DESC_TOP, 0);
			chk(q, top_m & 255);
			settle;
			chk(desc, {top_m[7:0], mid_m[7:0], low, 9'h0});
		end
		for (e = 0; e < 8; e++) begin
			cfg_m = $urandom;
			pwr_m = $urandom;
			idle <= e[0];
			sleep <= e[1];
			drv <= e[2];
			wb(1, `OFS_MOD_CFG, cfg_m);
			wb(1, `OFS_PWR_CTRL, pwr_m);
			wb(0, `OFS_MOD_CFG, 0);
			chk(q, cfg_m & 8'hd1);
			wb(0, `OFS_PWR_CTRL, 0);
			chk(q, pwr_m & 2);
			settle;
			chk(eye, cfg_m[7]);
			chk(oem, cfg_m[6] & e[2]);
			chk(stp, cfg_m[4] & e[0]);
			v = pwr_m[1] | (cfg_m[0] & e[1]);
			chk(susp, v);
			chk(c48, !v);
		end
		wb(1, `OFS_MOD_CFG, 0);
		wb(1, `OFS_PWR_CTRL, 0);
		idle <= 0;
		sleep <= 0;
		for (e = 0; e < 16; e++) begin
			v = $urandom;
			ep_m[e] = v & 8'hdf;
			wb(1, 8'(`OFS_EP_BASE + 4 * e), v);
			wb(0, 8'(`OFS_EP_BASE + 4 * e), 0);
			chk(q, ep_m[e]);
			send(pids[e % 4], e, ep_m[e]);
		end
		// every enable combination, all token kinds
		for (k = 0; k < 32; k++) begin
			wb(1, 8'(`OFS_EP_BASE + 12), k & 8'h1d);
			for (e = 0; e < 4; e++) begin
				send(pids[e], 3, k & 8'h1d);
			end
		end
		for (k = 0; k < 8; k++) begin
			host <= k[2];
			wb(1, `OFS_EP_BASE, k << 6);
			settle;
			chk(lsd, k[2] & k[1]);
			chk(pre, k[2] & !k[1]);
			chk(nakr, k[2] & !k[0]);
		end
		wb(1, 8'(`OFS_EP_BASE + 28), 0);
		wb(1, 8'(`OFS_EP_BASE + 32), 0);
		stl <= 1;
		stl_ep <= 4'h7;
		@(posedge CLK);
		stl <= 0;
		@(posedge CLK);
		wb(0, 8'(`OFS_EP_BASE + 28), 0);
		chk(q, 2);
		wb(0, 8'(`OFS_EP_BASE + 32), 0);
		chk(q, 0);
		wb(1, 8'(`OFS_EP_BASE + 28), 0);
		wb(0, 8'(`OFS_EP_BASE + 28), 0);
		chk(q, 0);
		// software clear and hardware stall on the same edge: the stall wins
		fork
			wb(1, 8'(`OFS_EP_BASE + 28), 0);
			begin
				stl <= 1;
				repeat (2) @(posedge CLK);
				stl <= 0;
			end
		join
		wb(0, 8'(`OFS_EP_BASE + 28), 0);
		chk(q, 2);
		conclude;
	end
endmodule
